// *** dv/ifd_decoder_sva.sv ***
`timescale 1ns/10ps
module ifd_decoder_sva (
    input wire clock,                       // Core clock
    input wire rst_n,                       // Async reset, active low
    input wire [31:0] instr_word,           // Word in
    input wire instr_valid,                 // Word valid
    input wire [7:0] reg_addr,              // Register address
    input wire [31:0] reg_wdata,            // Register write data
    input wire reg_wr,                      // Write strobe
    input wire reg_rd,                      // Read strobe
    input wire [31:0] reg_rdata_r,          // Read data
    input wire dec_valid_r,                 // Decode pulse
    input wire [5:0] primary_op_code_r,     // Primary opcode
    input wire [9:0] extended_op_code_r,    // Extended opcode
    input wire arith_excess_enable_r,       // Overflow update enable
    input wire record_bit_r,                // Record bit
    input wire [31:0] branch_offset_long_r, // Long offset
    input wire [31:0] signed_immediate_r,   // Signed immediate
    input wire [31:0] unsigned_immediate_r, // Unsigned immediate
    input wire [4:0] value_source_gpr_r,    // GPR at 6:10
    input wire [4:0] second_source_gpr_r,   // GPR at 16:20
    input wire [7:0] field_update_mask_r,   // Field mask
    input wire [9:0] special_reg_select_r   // Split select
);
    // ----------------------------------------------------------------
    // Decode enable mirror, kept from control writes
    // ----------------------------------------------------------------
    reg en_r; // Mirror of the enable bit
    wire acc = instr_valid && en_r; // Word taken this edge

    // Enable resets to one, so words are taken straight after reset
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            en_r <= 1'b1;
        end else if (reg_wr && reg_addr == 8'h00) begin
            en_r <= reg_wdata[0];
        end
    end

    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);

    op_code_a: assert property (
        acc |=> primary_op_code_r == $past(instr_word[31:26])) else $error("opcode wrong");
    ext_op_a: assert property (
        acc |=> {extended_op_code_r, arith_excess_enable_r} ==
        {$past(instr_word[10:1]), $past(instr_word[10])})
        else $error("extended opcode wrong");
    record_bit_a: assert property (
        acc |=> record_bit_r == $past(instr_word[0])) else $error("record bit wrong");
    branch_off_a: assert property (
        acc |=> branch_offset_long_r == {{6{$past(instr_word[25])}}, $past(instr_word[25:2]),
        2'b00}) else $error("long offset wrong");
    immed_values_a: assert property (
        acc |=> signed_immediate_r == {{16{$past(instr_word[15])}}, $past(instr_word[15:0])}
        && unsigned_immediate_r == {16'h0000, $past(instr_word[15:0])}) else $error("imm wrong");
    gpr_sel_a: assert property (
        acc |=> {value_source_gpr_r, second_source_gpr_r} == $past({instr_word[25:21],
        instr_word[15:11]})) else $error("gpr select wrong");
    mask_split_a: assert property (
        acc |=> {field_update_mask_r, special_reg_select_r} == $past({instr_word[19:12],
        instr_word[20:11]})) else $error("mask or split wrong");
    valid_pulse_a: assert property (
        1'b1 |=> dec_valid_r == $past(acc)) else $error("decode pulse wrong");
    held_fields_a: assert property (
        !acc |=> $stable(branch_offset_long_r) && $stable(value_source_gpr_r))
        else $error("fields moved without a word");
    rdata_idle_a: assert property (
        !reg_rd |=> reg_rdata_r == 32'h0000_0000) else $error("read data not idle");
endmodule // ifd_decoder_sva

bind ifd_decoder ifd_decoder_sva i_sva (.clock, .rst_n, .instr_word, .instr_valid, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata_r, .dec_valid_r, .primary_op_code_r,
    .extended_op_code_r, .arith_excess_enable_r, .record_bit_r, .branch_offset_long_r,
    .signed_immediate_r, .unsigned_immediate_r, .value_source_gpr_r, .second_source_gpr_r,
    .field_update_mask_r, .special_reg_select_r);

// *** dv/ifd_decoder_tb_top.sv ***
`timescale 1ns/10ps
module ifd_decoder_tb_top;
    reg clock = 1'b0, rst_n = 1'b0, req = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0; // Bench drives
    reg [31:0] req_word = 32'h0000_0000, reg_wdata = 32'h0000_0000, lastw; // Words
    reg [7:0] reg_addr = 8'h00; // Register address
    integer failures = 0, n_checks = 0, i; // Counters
    wire [31:0] instr_word, reg_rdata_r, branch_offset_long_r, load_store_disp_r;
    wire [31:0] signed_immediate_r, unsigned_immediate_r;
    wire [9:0] extended_op_code_r, special_reg_select_r, device_ctrl_reg_select_r;
    wire [9:0] time_base_reg_select_r;
    wire [8:0] extended_op_code_oe_r;
    wire [7:0] field_update_mask_r;
    wire [5:0] primary_op_code_r;
    wire [4:0] value_source_gpr_r, first_source_gpr_r, second_source_gpr_r, dest_cond_bit_r;
    wire [4:0] mask_first_bit_r, mask_stop_bit_r, rotate_count_r, string_byte_count_r;
    wire [4:0] trap_condition_mask_r;
    wire [2:0] target_cond_field_r, source_cond_field_r;
    wire instr_valid, dec_valid_r, arith_excess_enable_r, record_bit_r, link_update_bit_r;
    wire external_int_enable_r;

    always #10 clock = ~clock; // 50 MHz

    ifd_fetch_model i_fetch (.clock, .rst_n, .req, .req_word, .instr_valid, .instr_word);
    ifd_decoder i_dut (.clock, .rst_n, .instr_word, .instr_valid, .reg_addr, .reg_wdata,
        .reg_wr, .reg_rd, .reg_rdata_r, .dec_valid_r, .primary_op_code_r, .extended_op_code_r,
        .extended_op_code_oe_r, .arith_excess_enable_r, .record_bit_r, .link_update_bit_r,
        .branch_offset_long_r, .load_store_disp_r, .signed_immediate_r, .unsigned_immediate_r,
        .value_source_gpr_r, .first_source_gpr_r, .second_source_gpr_r, .dest_cond_bit_r,
        .target_cond_field_r, .source_cond_field_r, .field_update_mask_r, .mask_first_bit_r,
        .mask_stop_bit_r, .rotate_count_r, .string_byte_count_r, .special_reg_select_r,
        .device_ctrl_reg_select_r, .time_base_reg_select_r, .external_int_enable_r,
        .trap_condition_mask_r);

    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task cmp(input [63:0] got, input [63:0] exp);
        begin
            n_checks = n_checks + 1;
            if (got !== exp) begin
                failures = failures + 1;
                $display("mismatch at %0t ns: got %h exp %h", $time, got, exp);
            end
        end
    endtask

    // One strobe cycle; a read compares the data in the following cycle
    task reg_io(input wr, input [7:0] a, input [31:0] d);
        begin
            @(posedge clock);
            reg_wr <= wr;
            reg_rd <= !wr;
            reg_addr <= a;
            reg_wdata <= d;
            @(posedge clock);
            reg_wr <= 1'b0;
            reg_rd <= 1'b0;
            #1;
            if (!wr) cmp(reg_rdata_r, d);
        end
    endtask

    // Fields of the word taken one edge earlier
    task check_fields(input [31:0] w, input v);
        begin
            cmp(dec_valid_r, v);
            cmp(primary_op_code_r, w[31:26]);
            cmp({extended_op_code_r, extended_op_code_oe_r, arith_excess_enable_r},
                {w[10:1], w[9:1], w[10]});
            cmp({record_bit_r, link_update_bit_r}, {2{w[0]}});
            cmp(branch_offset_long_r, {{6{w[25]}}, w[25:2], 2'b00});
            cmp({load_store_disp_r, signed_immediate_r}, {2{{16{w[15]}}, w[15:0]}});
            cmp(unsigned_immediate_r, {16'h0000, w[15:0]});
            cmp({value_source_gpr_r, first_source_gpr_r, second_source_gpr_r}, w[25:11]);
            cmp({dest_cond_bit_r, target_cond_field_r, source_cond_field_r},
                {w[25:21], w[25:23], w[20:18]});
            cmp(field_update_mask_r, w[19:12]);
            cmp({mask_first_bit_r, mask_stop_bit_r}, w[10:1]);
            cmp({rotate_count_r, string_byte_count_r}, {2{w[15:11]}});
            cmp({special_reg_select_r, device_ctrl_reg_select_r, time_base_reg_select_r},
                {3{w[20:11]}});
            cmp(external_int_enable_r, w[15]);
            cmp(trap_condition_mask_r, w[25:21]);
        end
    endtask

    // Two words on consecutive edges, each checked in its own cycle
    task pair(input [31:0] w1, input [31:0] w2);
        begin
            @(posedge clock);
            req <= 1'b1;
            req_word <= w1;
            @(posedge clock);
            req_word <= w2;
            #1 check_fields(w1, 1'b1);
            @(posedge clock);
            req <= 1'b0;
            #1 check_fields(w2, 1'b1);
            lastw = w2;
        end
    endtask

    task wrap_up;
        begin
            $display("checks %0d failures %0d", n_checks, failures);
            if (failures == 0 && n_checks > 0) $display("SIMULATION PASSED");
            else $display("SIMULATION FAILED");
            $finish;
        end
    endtask

    // Watchdog: the whole run is well under this bound
    initial begin
        #2000000;
        failures = failures + 1;
        $display("watchdog expired");
        wrap_up;
    end

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (16) @(posedge clock);
        rst_n <= 1'b1;
        reg_io(1'b0, 8'h00, 32'h0000_0001);
        reg_io(1'b0, 8'h08, 32'h0000_0000);
        $display("test reset_values done");
        // Walking one exposes any swapped or shifted bit position
        for (i = 0; i < 32; i = i + 2) pair(32'h0000_0001 << i, 32'h0000_0001 << (i + 1));
        pair(32'hFFFF_FFFF, 32'h0000_0000);
        pair(32'h5555_5555, 32'hAAAA_AAAA);
        pair(32'h8000_8001, 32'h7FFF_7FFE); // Sign boundaries
        @(posedge clock);
        #1 cmp(dec_valid_r, 1'b0);
        $display("test decode done");
        // Sixteen walking pairs plus three pairs: 38 words taken
        reg_io(1'b0, 8'h08, 32'h0000_0026);
        // Disabled decode must leave every field where it was
        reg_io(1'b1, 8'h08, 32'h0000_0000);
        reg_io(1'b1, 8'h00, 32'h0000_0000);
        @(posedge clock);
        req <= 1'b1;
        req_word <= 32'h1234_5678;
        @(posedge clock);
        req_word <= 32'h9ABC_DEF0;
        #1 check_fields(lastw, 1'b0);
        @(posedge clock);
        req <= 1'b0;
        #1 check_fields(lastw, 1'b0);
        reg_io(1'b1, 8'h00, 32'h0000_0001);
        reg_io(1'b0, 8'h08, 32'h0000_0000);
        reg_io(1'b0, 8'h04, 32'h7FFF_7FFE);
        $display("test disable done");
        reg_io(1'b1, 8'h0C, 32'hFFFF_FFFF);
        reg_io(1'b0, 8'h0C, 32'h0000_0000);
        reg_io(1'b0, 8'h00, 32'h0000_0001);
        $display("test unmapped done");
        wrap_up;
    end
endmodule // ifd_decoder_tb_top

// *** dv/ifd_fetch_model.sv ***
`timescale 1ns/10ps
// ----------------------------------------------------------------
// Fetch stage stand-in: presents one word per requested cycle
// ----------------------------------------------------------------
module ifd_fetch_model (
    input wire clock,           // Core clock
    input wire rst_n,           // Async reset, active low
    input wire req,             // Bench wants a word this cycle
    input wire [31:0] req_word, // Word to present
    output wire instr_valid,    // Word valid
    output wire [31:0] instr_word // Word lines
);
    reg [31:0] last_r; // Last word presented

    // Idle lines carry the inverse of the last word, never a stale copy
    assign instr_valid = req;
    assign instr_word = req ? req_word : ~last_r;

    // Remember the last word that was presented
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            last_r <= 32'h0000_0000;
        end else if (req) begin
            last_r <= req_word;
        end
    end
endmodule // ifd_fetch_model

// *** rtl/ifd_consts.vh ***
`ifndef IFD_CONSTS_VH
`define IFD_CONSTS_VH

// ----------------------------------------------------------------
// Instruction word geometry (bit 0 is the most significant bit)
// ----------------------------------------------------------------
`define IFD_WORD_W 32

// Field first bit and length, numbered from the MSB as bit 0
`define IFD_PRIM_POS 0
`define IFD_PRIM_LEN 6
`define IFD_EXT_POS 21
`define IFD_EXT_LEN 10
`define IFD_EXTOE_POS 22
`define IFD_EXTOE_LEN 9
`define IFD_OE_POS 21
`define IFD_REC_POS 31
`define IFD_BOFF_POS 6
`define IFD_BOFF_LEN 24
`define IFD_IMM_POS 16
`define IFD_IMM_LEN 16
`define IFD_RD_POS 6
`define IFD_SRC1_POS 11
`define IFD_SRC2_POS 16
`define IFD_REG_LEN 5
`define IFD_CRF_D_POS 6
`define IFD_CRF_S_POS 11
`define IFD_CRF_LEN 3
`define IFD_FMASK_POS 12
`define IFD_FMASK_LEN 8
`define IFD_MSTART_POS 21
`define IFD_MSTOP_POS 26
`define IFD_SPLIT_POS 11
`define IFD_SPLIT_LEN 10
`define IFD_E_POS 16

// ----------------------------------------------------------------
// Register port map (byte addresses)
// ----------------------------------------------------------------
`define IFD_REG_CTRL 8'h00
`define IFD_REG_LAST 8'h04
`define IFD_REG_COUNT 8'h08

// Control register fields and reset value
`define IFD_CTRL_EN_BIT 0
`define IFD_CTRL_RESET 32'h0000_0001

`endif

// *** rtl/ifd_decoder.v ***
// Design decisions made here: the strobed register port and the address map.
`timescale 1ns/10ps
`include "ifd_consts.vh"

module ifd_decoder (
    input wire clock,                       // System clock, 50 MHz
    input wire rst_n,                       // Asynchronous reset, active low
    input wire [31:0] instr_word,           // Instruction word from fetch
    input wire instr_valid,                 // Word is valid this cycle
    input wire [7:0] reg_addr,              // Register byte address
    input wire [31:0] reg_wdata,            // Register write data
    input wire reg_wr,                      // Register write strobe
    input wire reg_rd,                      // Register read strobe
    output reg [31:0] reg_rdata_r,          // Read data, cycle after strobe
    output reg dec_valid_r,                 // Decoded fields valid
    output reg [5:0] primary_op_code_r,     // Primary opcode
    output reg [9:0] extended_op_code_r,    // Extended opcode, no OE form
    output reg [8:0] extended_op_code_oe_r, // Extended opcode, OE form
    output reg arith_excess_enable_r,       // Overflow flag update enable
    output reg record_bit_r,                // Condition flag update
    output reg link_update_bit_r,           // Return address load
    output reg [31:0] branch_offset_long_r, // Long branch offset, 32 bits
    output reg [31:0] load_store_disp_r,    // Load/store displacement
    output reg [31:0] signed_immediate_r,   // Signed immediate, extended
    output reg [31:0] unsigned_immediate_r, // Unsigned immediate
    output reg [4:0] value_source_gpr_r,    // Dest / value source GPR
    output reg [4:0] first_source_gpr_r,    // First source / dest GPR
    output reg [4:0] second_source_gpr_r,   // Second source GPR
    output reg [4:0] dest_cond_bit_r,       // Destination condition bit
    output reg [2:0] target_cond_field_r,   // Target condition field
    output reg [2:0] source_cond_field_r,   // Source condition field
    output reg [7:0] field_update_mask_r,   // Condition field mask
    output reg [4:0] mask_first_bit_r,      // Rotate mask start
    output reg [4:0] mask_stop_bit_r,       // Rotate mask end
    output reg [4:0] rotate_count_r,        // Shift amount
    output reg [4:0] string_byte_count_r,   // String byte count
    output reg [9:0] special_reg_select_r,  // Special register split field
    output reg [9:0] device_ctrl_reg_select_r, // Device control split field
    output reg [9:0] time_base_reg_select_r,   // Time base split field
    output reg external_int_enable_r,       // Interrupt enable value
    output reg [4:0] trap_condition_mask_r  // Trap conditions
);

    // ----------------------------------------------------------------
    // Field extraction helper
    // ----------------------------------------------------------------
    // Pulls len bits starting at MSB-numbered position pos, right aligned.
    // Shifting avoids variable part-selects, which some tools reject.
    function [31:0] ifd_bits;
        input [31:0] w;
        input integer pos;
        input integer len;
        begin
            ifd_bits = (w << pos) >> (32 - len);
        end
    endfunction

    // Single bit at MSB-numbered position pos
    function ifd_bit;
        input [31:0] w;
        input integer pos;
        begin
            ifd_bit = w[31 - pos];
        end
    endfunction

    // ----------------------------------------------------------------
    // Register state
    // ----------------------------------------------------------------
    reg [31:0] ctrl_r;      // Control: bit 0 enables decoding
    reg [31:0] last_word_r; // Last word accepted for decode
    reg [31:0] count_r;     // Number of words decoded
    wire dec_en;            // Decode enable from control
    wire take;              // Word accepted this cycle

    assign dec_en = ctrl_r[`IFD_CTRL_EN_BIT];
    assign take = instr_valid & dec_en;

    // ----------------------------------------------------------------
    // Combinational field extraction
    // ----------------------------------------------------------------
    // Every field is cut from the same word at once; one output stage
    // keeps outputs glitch-free at the cost of one cycle.
    wire [31:0] prim_w; // Primary opcode, padded
    wire [31:0] ext_w; // Extended opcode, no OE form
    wire [31:0] ext_oe_w; // Extended opcode, OE form
    wire [31:0] boff_w; // Long offset, padded
    wire [31:0] imm_w; // Low half-word
    wire [31:0] rd_w; // Bits 6:10
    wire [31:0] src1_w; // Bits 11:15
    wire [31:0] src2_w; // Bits 16:20
    wire [31:0] tfield_w; // Bits 6:8
    wire [31:0] sfield_w; // Bits 11:13
    wire [31:0] fmask_w; // Bits 12:19
    wire [31:0] mstart_w; // Bits 21:25
    wire [31:0] mstop_w; // Bits 26:30
    wire [31:0] split_w; // Bits 11:20
    wire [31:0] boff_ext_w; // Long offset, shifted and extended

    assign prim_w = ifd_bits(instr_word, `IFD_PRIM_POS, `IFD_PRIM_LEN);
    assign ext_w = ifd_bits(instr_word, `IFD_EXT_POS, `IFD_EXT_LEN);
    assign ext_oe_w = ifd_bits(instr_word, `IFD_EXTOE_POS, `IFD_EXTOE_LEN);
    assign boff_w = ifd_bits(instr_word, `IFD_BOFF_POS, `IFD_BOFF_LEN);
    assign imm_w = ifd_bits(instr_word, `IFD_IMM_POS, `IFD_IMM_LEN);
    assign rd_w = ifd_bits(instr_word, `IFD_RD_POS, `IFD_REG_LEN);
    assign src1_w = ifd_bits(instr_word, `IFD_SRC1_POS, `IFD_REG_LEN);
    assign src2_w = ifd_bits(instr_word, `IFD_SRC2_POS, `IFD_REG_LEN);
    assign tfield_w = ifd_bits(instr_word, `IFD_CRF_D_POS, `IFD_CRF_LEN);
    assign sfield_w = ifd_bits(instr_word, `IFD_CRF_S_POS, `IFD_CRF_LEN);
    assign fmask_w = ifd_bits(instr_word, `IFD_FMASK_POS, `IFD_FMASK_LEN);
    assign mstart_w = ifd_bits(instr_word, `IFD_MSTART_POS, `IFD_REG_LEN);
    assign mstop_w = ifd_bits(instr_word, `IFD_MSTOP_POS, `IFD_REG_LEN);
    assign split_w = ifd_bits(instr_word, `IFD_SPLIT_POS, `IFD_SPLIT_LEN);
    // Append two zero bits, then copy the sign across the top six
    assign boff_ext_w = {{6{boff_w[23]}}, boff_w[23:0], 2'b00};

    // ----------------------------------------------------------------
    // Decoded field outputs
    // ----------------------------------------------------------------
    // Fields update only on an accepted word; they hold otherwise.
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            dec_valid_r <= 1'b0;
            primary_op_code_r <= 6'h00;
            extended_op_code_r <= 10'h000;
            extended_op_code_oe_r <= 9'h000;
            arith_excess_enable_r <= 1'b0;
            record_bit_r <= 1'b0;
            link_update_bit_r <= 1'b0;
            branch_offset_long_r <= 32'h0000_0000;
            load_store_disp_r <= 32'h0000_0000;
            signed_immediate_r <= 32'h0000_0000;
            unsigned_immediate_r <= 32'h0000_0000;
            value_source_gpr_r <= 5'h00;
            first_source_gpr_r <= 5'h00;
            second_source_gpr_r <= 5'h00;
            dest_cond_bit_r <= 5'h00;
            target_cond_field_r <= 3'h0;
            source_cond_field_r <= 3'h0;
            field_update_mask_r <= 8'h00;
            mask_first_bit_r <= 5'h00;
            mask_stop_bit_r <= 5'h00;
            rotate_count_r <= 5'h00;
            string_byte_count_r <= 5'h00;
            special_reg_select_r <= 10'h000;
            device_ctrl_reg_select_r <= 10'h000;
            time_base_reg_select_r <= 10'h000;
            external_int_enable_r <= 1'b0;
            trap_condition_mask_r <= 5'h00;
        end else begin
            dec_valid_r <= take;
            if (take) begin
                // Opcodes, read as plain unsigned numbers
                primary_op_code_r <= prim_w[5:0];
                extended_op_code_r <= ext_w[9:0];
                extended_op_code_oe_r <= ext_oe_w[8:0];
                // Flag bits; the consumer picks by instruction form
                arith_excess_enable_r <= ifd_bit(instr_word, `IFD_OE_POS);
                record_bit_r <= ifd_bit(instr_word, `IFD_REC_POS);
                link_update_bit_r <= ifd_bit(instr_word, `IFD_REC_POS);
                // Offsets and immediates
                branch_offset_long_r <= boff_ext_w;
                load_store_disp_r <= {{16{imm_w[15]}}, imm_w[15:0]};
                signed_immediate_r <= {{16{imm_w[15]}}, imm_w[15:0]};
                unsigned_immediate_r <= {16'h0000, imm_w[15:0]};
                // Register selectors
                value_source_gpr_r <= rd_w[4:0];
                first_source_gpr_r <= src1_w[4:0];
                second_source_gpr_r <= src2_w[4:0];
                // Condition selectors
                dest_cond_bit_r <= rd_w[4:0];
                target_cond_field_r <= tfield_w[2:0];
                source_cond_field_r <= sfield_w[2:0];
                field_update_mask_r <= fmask_w[7:0];
                // Rotate, shift and string counts
                mask_first_bit_r <= mstart_w[4:0];
                mask_stop_bit_r <= mstop_w[4:0];
                rotate_count_r <= src2_w[4:0];
                string_byte_count_r <= src2_w[4:0];
                // Split field passed raw; halves are not swapped here
                special_reg_select_r <= split_w[9:0];
                device_ctrl_reg_select_r <= split_w[9:0];
                time_base_reg_select_r <= split_w[9:0];
                external_int_enable_r <= ifd_bit(instr_word, `IFD_E_POS);
                trap_condition_mask_r <= rd_w[4:0];
            end
        end
    end

    // ----------------------------------------------------------------
    // Software-visible state
    // ----------------------------------------------------------------
    // Counter wraps; software takes differences, so wrap is harmless.
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_r <= `IFD_CTRL_RESET;
            last_word_r <= 32'h0000_0000;
            count_r <= 32'h0000_0000;
        end else begin
            // Only bit 0 is kept; others read as zero
            if (reg_wr && reg_addr == `IFD_REG_CTRL) begin
                ctrl_r <= {31'h0000_0000, reg_wdata[`IFD_CTRL_EN_BIT]};
            end
            if (take) begin
                last_word_r <= instr_word;
            end
            // A software clear in the same cycle as a decode event leaves the count at one
            if (take) begin
                count_r <= (reg_wr && reg_addr == `IFD_REG_COUNT) ?
                    32'h0000_0001 : count_r + 32'h0000_0001;
            end else if (reg_wr && reg_addr == `IFD_REG_COUNT) begin
                count_r <= 32'h0000_0000;
            end
        end
    end

    // ----------------------------------------------------------------
    // Register read port
    // ----------------------------------------------------------------
    // Data stand one cycle after the strobe, zero otherwise.
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata_r <= 32'h0000_0000;
        end else if (!reg_rd) begin
            reg_rdata_r <= 32'h0000_0000;
        end else if (reg_addr == `IFD_REG_CTRL) begin
            reg_rdata_r <= ctrl_r;
        end else if (reg_addr == `IFD_REG_LAST) begin
            reg_rdata_r <= last_word_r;
        end else if (reg_addr == `IFD_REG_COUNT) begin
            reg_rdata_r <= count_r;
        end else begin
            // Unmapped addresses read as zero
            reg_rdata_r <= 32'h0000_0000;
        end
    end

endmodule // ifd_decoder
